//--- bsc_regs.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bsc_cfg.svh"
// Summary of operation
// - Frame-sync polarity bit, 1 active low, reset 1
// - Data delay bit adds one bit period
// - Width field: half duty, slot, one bit
// - Alternate-line mode overflows at 4096 pixels
// - Left/right, alternate-pixel overflow at 8192 pixels
// - Stereo error flags clear on status read
// - Video fault flag set on processing fault
// - Alternate-line odd/even length mismatch sets flag
// - Left/right mismatch when line not twice size
// - Bits 7-6 delay second port input
// - Bits 5-4 delay first port input
// - Dual status needs both active, measurable skew
// - Skew sign 1 when second port leads
// - Skew magnitude read-only in pixel clocks
// - Link ready after downstream found and probed
// - Transmit active needs video, lock, mode
// - Port mode field valid while transmitting
// - Clock detect mirrors selected port indication
// - Per-port bits follow the selected port
// - Clock-mode field selects port in independent mode
module bsc_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic independent_mode,
	input wire bsc_pkg::bsc_3d_mode_t stereo_mode,
	input wire logic [13:0] image_line_size,
	input wire logic line_end,
	input wire logic [13:0] line_length,
	input wire logic line_odd,
	input wire logic stereo_video_fault_evt,
	input wire logic first_port_active,
	input wire logic second_port_active,
	input wire logic skew_in_range,
	input wire logic skew_second_leads,
	input wire logic [1:0] skew_count,
	input wire logic [1:0] serial_link_ready_in,
	input wire logic [1:0] video_input_valid,
	input wire logic [1:0] tx_active_in,
	input wire logic [1:0] rx_locked_in,
	input wire logic [1:0] mode_entered_in,
	input wire logic [1:0] serial_port_mode_in,
	input wire logic [1:0] input_clock_detected_in,
	output logic frame_sync_polarity,
	output logic tdm_data_delay,
	output bsc_pkg::bsc_fs_width_t frame_sync_pulse_width,
	output logic [1:0] second_port_input_delay,
	output logic [1:0] first_port_input_delay,
	output logic [1:0] bridge_clock_mode,
	output logic selected_port
);
	import bsc_pkg::*;

	//----------------------------------------
	// Storage
	//----------------------------------------
	logic [3:0] tdm_q;
	logic [2:0] err_q;
	logic [2:0] err_d;
	logic [3:0] dly_q;
	logic [1:0] mode_q;
	logic [13:0] prev_len_q;
	logic prev_valid_q;
	logic [11:0] awaddr_q;
	logic aw_held_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic w_held_q;
	bsc_wr_state_t wr_state_q;
	logic do_write;
	logic rd_take;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic sel;
	logic [13:0] limit;
	logic ov_evt;
	logic mis_evt;

	// Decode a byte address to a known register
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == `BSC_ADDR_TDM) || (a == `BSC_ADDR_3D) || (a == `BSC_ADDR_SKEW) ||
			(a == `BSC_ADDR_LINK) || (a == `BSC_ADDR_MODE);
	endfunction

	//----------------------------------------
	// Write channel
	//----------------------------------------
	assign s_axi_awready = !aw_held_q && (wr_state_q == BSC_WR_IDLE);
	assign s_axi_wready = !w_held_q && (wr_state_q == BSC_WR_IDLE);
	assign do_write = aw_held_q && w_held_q && (wr_state_q == BSC_WR_IDLE);
	assign s_axi_bresp = 2'h0;
	assign s_axi_bvalid = (wr_state_q == BSC_WR_RESP);

	// Capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			w_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write response sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= BSC_WR_IDLE;
		end else begin
			case (wr_state_q)
				BSC_WR_IDLE: begin
					if (do_write) begin
						wr_state_q <= BSC_WR_RESP;
					end
				end
				BSC_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_q <= BSC_WR_IDLE;
					end
				end
				default: begin
					wr_state_q <= BSC_WR_IDLE;
				end
			endcase
		end
	end

	//----------------------------------------
	// Control registers
	//----------------------------------------
	// Writable fields, low byte lane only, upper bits dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tdm_q <= 4'(`BSC_TDM_RST);
			dly_q <= `BSC_SKEW_RST;
			mode_q <= 2'(`BSC_MODE_RST);
		end else if (do_write && wstrb_q[0]) begin
			if (awaddr_q == `BSC_ADDR_TDM) begin
				tdm_q <= wdata_q[3:0];
			end
			if (awaddr_q == `BSC_ADDR_SKEW) begin
				dly_q <= wdata_q[7:4];
			end
			if (awaddr_q == `BSC_ADDR_MODE) begin
				mode_q <= wdata_q[1:0];
			end
		end
	end

	assign frame_sync_polarity = tdm_q[`BSC_TDM_POL_BIT];
	assign tdm_data_delay = tdm_q[`BSC_TDM_DLY_BIT];
	assign frame_sync_pulse_width = bsc_fs_width_t'(tdm_q[1:0]);
	assign second_port_input_delay = dly_q[3:2];
	assign first_port_input_delay = dly_q[1:0];
	assign bridge_clock_mode = mode_q;
	assign selected_port = independent_mode & mode_q[0];

	//----------------------------------------
	// Stereo line checks
	//----------------------------------------
	always_comb begin
		limit = (stereo_mode == BSC_3D_ALT_LINE) ? `BSC_ALT_LINE_LIMIT : `BSC_LR_LINE_LIMIT;
		ov_evt = line_end && (stereo_mode != BSC_3D_OFF) && ({1'b0, line_length} >= {1'b0, limit});
		mis_evt = 1'b0;
		if (line_end && stereo_mode == BSC_3D_ALT_LINE && line_odd == 1'b0 && prev_valid_q) begin
			mis_evt = (line_length != prev_len_q);
		end
		if (line_end && stereo_mode == BSC_3D_LEFT_RIGHT) begin
			mis_evt = (line_length != {image_line_size[12:0], 1'b0});
		end
	end

	// Remember odd line length for pairing with even line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_len_q <= 14'h0000;
			prev_valid_q <= 1'b0;
		end else if (line_end) begin
			prev_len_q <= line_length;
			prev_valid_q <= line_odd;
		end
	end

	// Sticky flags, set wins over read clear
	always_comb begin
		err_d = err_q;
		if (rd_take && s_axi_araddr == `BSC_ADDR_3D) begin
			err_d = 3'h0;
		end
		if (ov_evt) begin
			err_d[`BSC_3D_OV_BIT] = 1'b1;
		end
		if (stereo_video_fault_evt) begin
			err_d[`BSC_3D_VID_BIT] = 1'b1;
		end
		if (mis_evt) begin
			err_d[`BSC_3D_MIS_BIT] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_q <= 3'h0;
		end else begin
			err_q <= err_d;
		end
	end

	//----------------------------------------
	// Read channel
	//----------------------------------------
	assign rd_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !s_axi_rvalid;
	assign sel = independent_mode & mode_q[0];

	// Assemble read data
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = addr_known(s_axi_araddr);
		case (s_axi_araddr)
			`BSC_ADDR_TDM: rd_byte = {4'h0, tdm_q};
			`BSC_ADDR_3D: rd_byte = {5'h00, err_q};
			`BSC_ADDR_SKEW: begin
				rd_byte = {dly_q, (first_port_active && second_port_active && skew_in_range),
					skew_second_leads, skew_count};
			end
			`BSC_ADDR_LINK: begin
				rd_byte[7] = serial_link_ready_in[sel];
				rd_byte[6] = video_input_valid[sel] && tx_active_in[sel] && rx_locked_in[sel] &&
					mode_entered_in[sel];
				rd_byte[5:4] = rd_byte[6] ? serial_port_mode_in : 2'h0;
				rd_byte[3] = input_clock_detected_in[sel];
			end
			`BSC_ADDR_MODE: rd_byte = {6'h00, mode_q};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

//--- bsc_cfg.svh
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
// Register indices and byte addresses
`define BSC_IDX_TDM 8'h57
`define BSC_IDX_3D 8'h58
`define BSC_IDX_SKEW 8'h59
`define BSC_IDX_LINK 8'h5a
`define BSC_IDX_MODE 8'h5b
`define BSC_ADDR_TDM 12'h15c
`define BSC_ADDR_3D 12'h160
`define BSC_ADDR_SKEW 12'h164
`define BSC_ADDR_LINK 12'h168
`define BSC_ADDR_MODE 12'h16c
// Reset values
`define BSC_TDM_RST 8'h0a
`define BSC_SKEW_RST 4'h0
`define BSC_MODE_RST 8'h00
// Field positions
`define BSC_TDM_POL_BIT 3
`define BSC_TDM_DLY_BIT 2
`define BSC_3D_OV_BIT 2
`define BSC_3D_VID_BIT 1
`define BSC_3D_MIS_BIT 0
// Line length limits
`define BSC_ALT_LINE_LIMIT 14'd4096
`define BSC_LR_LINE_LIMIT 14'd8192
`endif

//--- bsc_pkg.sv
package bsc_pkg;
	typedef enum logic [1:0] {
		BSC_FS_HALF = 2'h0,
		BSC_FS_SLOT = 2'h1,
		BSC_FS_BIT = 2'h2,
		BSC_FS_BIT2 = 2'h3
	} bsc_fs_width_t;
	typedef enum logic [1:0] {
		BSC_3D_OFF = 2'h0,
		BSC_3D_ALT_LINE = 2'h1,
		BSC_3D_LEFT_RIGHT = 2'h2,
		BSC_3D_ALT_PIXEL = 2'h3
	} bsc_3d_mode_t;
	typedef enum logic [2:0] {
		BSC_WR_IDLE = 3'b001,
		BSC_WR_RESP = 3'b010,
		BSC_WR_SPARE = 3'b100
	} bsc_wr_state_t;
endpackage

//--- bsc_regs_props.sv
`timescale 1ns/1ps
// ----------
// Bus handshake and selected-port checks
// ----------
module bsc_regs_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic independent_mode,
	input wire logic [1:0] bridge_clock_mode,
	input wire logic selected_port
);
	// One clock, one reset
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Address and data taken at one edge
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence resp_two;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	chk_wr_answer: assert property (wr_take |=> resp_two)
		else $error("late write response");
	chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stuck");
	chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read data");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data stuck");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	chk_sel_port: assert property (selected_port == (independent_mode & bridge_clock_mode[0]))
		else $error("wrong selected port");
endmodule
bind bsc_regs bsc_regs_props u_props (.*);

//--- bsc_regs_tb.sv
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module bsc_regs_tb;
	import bsc_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic [47:0] s, r;
	logic [15:0] lq;
	int err_count, n_checks;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_sync_polarity, tdm_data_delay;
	wire selected_port;
	wire [1:0] s_axi_bresp, s_axi_rresp, second_port_input_delay, first_port_input_delay, bridge_clock_mode;
	wire [31:0] s_axi_rdata;
	wire bsc_fs_width_t frame_sync_pulse_width;
	// Status inputs except the fixed image line size come from one word
	bsc_regs DUT (.*, .independent_mode(s[0]), .stereo_mode(bsc_3d_mode_t'(s[2:1])), .image_line_size(14'h1000),
		.line_end(s[3]), .line_length(s[17:4]), .line_odd(s[18]), .stereo_video_fault_evt(s[19]),
		.first_port_active(s[20]), .second_port_active(s[21]), .skew_in_range(s[22]), .skew_second_leads(s[23]),
		.skew_count(s[25:24]), .serial_link_ready_in(s[27:26]), .video_input_valid(s[29:28]), .tx_active_in(s[31:30]),
		.rx_locked_in(s[33:32]), .mode_entered_in(s[35:34]), .serial_port_mode_in(s[37:36]),
		.input_clock_detected_in(s[39:38]));
	// ----------
	// Helpers
	// ----------
	function logic [15:0] lf(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Expected link status for the selected port
	function logic [31:0] lk(input logic [47:0] v, input logic [1:0] c);
		logic p;
		logic t;
		p = v[0] & c[0];
		t = v[28 + p] & v[30 + p] & v[32 + p] & v[34 + p];
		return {24'h0, v[26 + p], t, t ? v[37:36] : 2'h0, v[38 + p], 3'h0};
	endfunction
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		logic [1:0] rb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			rb = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
		`CK(rb, 2'h0)
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tb;
		logic [33:0] g;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arready;
			tb = s_axi_rvalid;
			g = {s_axi_rresp, s_axi_rdata};
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tb);
		s_axi_rready <= 1'b0;
		`CK(g, {er, e})
	endtask
	// One line end pulse, then the stereo status read
	task t(input logic [13:0] n, input logic [1:0] m, input logic o, input logic f, input logic [2:0] e);
		s[19:1] <= {f, o, n, 1'b1, m};
		@(posedge aclk);
		s[19:1] <= 19'h0;
		@(posedge aclk);
		rd(12'h160, {29'h0, e}, 2'h0);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge aclk);
		err_count++;
		tally_and_finish();
	end
	// Test sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s, r} = 0;
		s_axi_wstrb = 4'h1;
		lq = 16'hf5f1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(12'h15c, 32'h0a, 2'h0);
		rd(12'h164, 32'h0, 2'h0);
		rd(12'h168, 32'h0, 2'h0);
		rd(12'h170, 32'h0, 2'h2);
		$display("reset test done");
		repeat (12) begin
			repeat (3) begin
				lq = lf(lq);
				r = {r[31:0], lq};
			end
			s <= r & ~48'h80008;
			wr(12'h15c, r[31:0]);
			wr(12'h164, r[43:12]);
			wr(12'h16c, r[39:8]);
			`CK({frame_sync_polarity, tdm_data_delay, frame_sync_pulse_width}, r[3:0])
			`CK({second_port_input_delay, first_port_input_delay}, r[19:16])
			`CK(bridge_clock_mode, r[9:8])
			`CK(selected_port, r[0] & r[8])
			rd(12'h15c, {28'h0, r[3:0]}, 2'h0);
			rd(12'h164, {24'h0, r[19:16], &r[22:20], r[23], r[25:24]}, 2'h0);
			rd(12'h168, lk(r, r[9:8]), 2'h0);
		end
		$display("random test done");
		t(14'h0fff, 2'h1, 1'b1, 1'b0, 3'h0);
		t(14'h1000, 2'h1, 1'b1, 1'b0, 3'h4);
		t(14'h0000, 2'h0, 1'b0, 1'b0, 3'h0);
		t(14'h2000, 2'h2, 1'b1, 1'b0, 3'h4);
		t(14'h2000, 2'h3, 1'b1, 1'b0, 3'h4);
		t(14'h1ffe, 2'h2, 1'b1, 1'b0, 3'h1);
		t(14'h0064, 2'h1, 1'b1, 1'b0, 3'h0);
		t(14'h0065, 2'h1, 1'b0, 1'b0, 3'h1);
		t(14'h0064, 2'h1, 1'b1, 1'b0, 3'h0);
		t(14'h0064, 2'h1, 1'b0, 1'b0, 3'h0);
		t(14'h0005, 2'h0, 1'b0, 1'b1, 3'h2);
		$display("stereo test done");
		tally_and_finish();
	end
endmodule
